// *** logic/bslk_pkg.sv ***
// Purpose: Shared constants for the block lock and soft reset interpreter
// Assumes: 100 MHz system clock, serial clock sampled by the system clock
// Notes: Lock index layout is a device map choice, kept here in one place
package bslk_pkg;
  localparam logic [7:0] OP_UNLOCK = 8'h39;
  localparam logic [7:0] OP_RD_LOCK = 8'h3D;
  localparam logic [7:0] OP_GLB_LOCK = 8'h7E;
  localparam logic [7:0] OP_GLB_UNLOCK = 8'h98;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam int CLK_MHZ = 100;
  localparam int T_RST_US = 30;
  localparam int RST_CYC = T_RST_US * CLK_MHZ;
  localparam int T_PUW_MS = 5;
  localparam int PUW_CYC = T_PUW_MS * 1000 * CLK_MHZ;
  localparam int REC_CNT_W = 12;
  localparam int PUW_CNT_W = 20;
  localparam int LOCK_IDX_LSB = 16;
  localparam int LOCK_IDX_W = 8;
  localparam int LOCK_CNT = 256;
  localparam int BP_W = 4;
  localparam logic [5:0] OP_LAST = 6'h07;
  localparam logic [5:0] ADDR3_LAST = 6'h17;
  localparam logic [5:0] ADDR4_LAST = 6'h1F;
  localparam logic [2:0] OUT_LSB_POS = 3'h7;
endpackage

// *** logic/bslk_lock_mem.sv ***
// Purpose: Volatile lock bit array with global set and clear
// Assumes: Synchronous active high reset, one write per cycle
// Notes: Read data come out of a register, one cycle after the index
`timescale 1ns/100ps
module bslk_lock_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic set_all,
  input wire logic clr_all,
  input wire logic clr_one,
  input wire logic [bslk_pkg::LOCK_IDX_W-1:0] wr_idx,
  input wire logic [bslk_pkg::LOCK_IDX_W-1:0] rd_idx,
  output logic rd_bit
);
  logic [bslk_pkg::LOCK_CNT-1:0] lock_reg;
  logic [bslk_pkg::LOCK_CNT-1:0] lock_next;
  logic rd_bit_next;

  always_comb begin
    lock_next = lock_reg;
    if (set_all) begin
      lock_next = '1;
    end else if (clr_all) begin
      lock_next = '0;
    end else if (clr_one) begin
      lock_next[wr_idx] = 1'b0;
    end
    rd_bit_next = lock_reg[rd_idx];
  end

  // Whole array comes up locked
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_reg <= '1; // [RULE2]
      rd_bit <= 1'b1;
    end else begin
      lock_reg <= lock_next;
      rd_bit <= rd_bit_next;
    end
  end
endmodule

// *** logic/bslk_ctrl.sv ***
// Purpose: Serial command interpreter for block locks and software reset
// Assumes: Serial pins are asynchronous; config inputs are on REF_CLK
// Notes: Serial clock must be slower than about a quarter of REF_CLK
//
// What this block does
// [RULE1] Lock bits protect only when per-block select is 1, else BP bits.
// [RULE2] All lock bits are volatile and read 1 after power-up or reset.
// [RULE3] Opcode 39h plus an address, then chip select high, unlocks it.
// [RULE4] Address is 32 bits in 4-byte mode and 24 bits otherwise.
// [RULE5] Opcode 3Dh plus address returns the lock byte MSB first.
// [RULE6] The returned byte has LSB 1 when locked and 0 when unlocked.
// [RULE7] Opcode 7Eh alone sets every lock bit.
// [RULE8] Opcode 98h alone clears every lock bit.
// [RULE9] Soft reset needs 66h then 99h as consecutive commands.
// [RULE10] Any command other than 99h after 66h cancels reset enable.
// [RULE11] Accepted reset aborts work and restores power-on volatile state.
// [RULE12] After reset the device ignores commands for about 30 us.
// [RULE13] The host should check busy and suspend before resetting.
// [RULE14] Writes are refused until 5 ms after power-up.
// [RULE15] Address bits map to a lock bit by the device memory map.
`timescale 1ns/100ps
module bslk_ctrl #(
  parameter int PUW_CYCLES = bslk_pkg::PUW_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic SERIAL_DATA_IN,
  input wire logic ADDR4_MODE,
  input wire logic PER_BLOCK_PROTECT_SELECT,
  input wire logic COMPLEMENT_PROTECT,
  input wire logic TOP_BOTTOM_SELECT,
  input wire logic [bslk_pkg::BP_W-1:0] BLOCK_PROTECT_BITS,
  output logic SDO,
  output logic SDO_OE,
  output logic LOCK_PROTECT,
  output logic BP_PROTECT_SEL,
  output logic [bslk_pkg::BP_W+1:0] BP_PROTECT_CODE,
  output logic SOFT_RESET,
  output logic RESET_BUSY,
  output logic WRITE_READY
);
  default clocking bslk_cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_OPDONE, ST_DATA, ST_EXTRA, ST_SKIP
  } bslk_state_t;

  localparam logic [bslk_pkg::REC_CNT_W-1:0] REC_LOAD =
    bslk_pkg::REC_CNT_W'(bslk_pkg::RST_CYC);
  localparam logic [bslk_pkg::PUW_CNT_W-1:0] PUW_DONE =
    bslk_pkg::PUW_CNT_W'(PUW_CYCLES);

  function automatic logic [bslk_pkg::LOCK_IDX_W-1:0] lock_index(
    input logic [31:0] addr
  );
    lock_index = addr[bslk_pkg::LOCK_IDX_LSB +: bslk_pkg::LOCK_IDX_W];
  endfunction

  // Pin synchronisers
  logic cs_meta, cs_sync, cs_dly;
  logic ck_meta, ck_sync, ck_dly;
  logic di_meta, di_sync;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_dly <= 1'b1;
      ck_meta <= 1'b0;
      ck_sync <= 1'b0;
      ck_dly <= 1'b0;
      di_meta <= 1'b0;
      di_sync <= 1'b0;
    end else begin
      cs_meta <= CS_N;
      cs_sync <= cs_meta;
      cs_dly <= cs_sync;
      ck_meta <= SCLK;
      ck_sync <= ck_meta;
      ck_dly <= ck_sync;
      di_meta <= SERIAL_DATA_IN;
      di_sync <= di_meta;
    end
  end

  logic sck_rise, sck_fall, cs_fall, cs_rise;
  assign sck_rise = ck_sync & ~ck_dly & ~cs_sync;
  assign sck_fall = ~ck_sync & ck_dly & ~cs_sync;
  assign cs_fall = ~cs_sync & cs_dly;
  assign cs_rise = cs_sync & ~cs_dly;

  bslk_state_t state_reg, state_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [7:0] op_reg, op_next;
  logic [31:0] addr_reg, addr_next;
  logic addr32_reg, addr32_next;
  logic [2:0] out_cnt_reg, out_cnt_next;
  logic sdo_reg, sdo_next;
  logic rst_en_reg, rst_en_next;
  logic [bslk_pkg::REC_CNT_W-1:0] rec_cnt_reg, rec_cnt_next;
  logic [bslk_pkg::PUW_CNT_W-1:0] puw_cnt_reg, puw_cnt_next;
  logic soft_rst_next;
  logic lock_set_all, lock_clr_all, lock_clr_one;
  logic op_valid, recovering, mem_rd_bit;
  logic [7:0] op_full;
  logic [5:0] addr_last;
  assign recovering = rec_cnt_reg != '0;
  assign op_full = {op_reg[6:0], di_sync};
  assign addr_last = addr32_reg ? bslk_pkg::ADDR4_LAST : bslk_pkg::ADDR3_LAST;
  // A whole opcode byte has been seen in these states
  assign op_valid = state_reg inside {ST_ADDR, ST_OPDONE, ST_DATA, ST_EXTRA};
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    addr32_next = addr32_reg;
    out_cnt_next = out_cnt_reg;
    sdo_next = sdo_reg;
    rst_en_next = rst_en_reg;
    soft_rst_next = 1'b0;
    lock_set_all = 1'b0;
    lock_clr_all = 1'b0;
    lock_clr_one = 1'b0;
    rec_cnt_next = recovering ? rec_cnt_reg - 1'b1 : rec_cnt_reg;
    if (cs_rise) begin
      state_next = ST_IDLE;
      if (op_valid) begin
        rst_en_next = (state_reg == ST_OPDONE) &&
                      (op_reg == bslk_pkg::OP_RST_EN); // [RULE10]
      end
      if (state_reg == ST_OPDONE) begin
        unique case (op_reg)
          bslk_pkg::OP_UNLOCK: lock_clr_one = 1'b1; // [RULE3]
          bslk_pkg::OP_GLB_LOCK: lock_set_all = 1'b1; // [RULE7]
          bslk_pkg::OP_GLB_UNLOCK: lock_clr_all = 1'b1; // [RULE8]
          bslk_pkg::OP_RST: begin
            if (rst_en_reg) begin
              soft_rst_next = 1'b1; // [RULE9]
              lock_set_all = 1'b1; // [RULE2]
              rec_cnt_next = REC_LOAD; // [RULE12]
            end
          end
          default: ;
        endcase
      end
    end else if (cs_fall) begin
      // No command is taken while recovering from a soft reset
      state_next = recovering ? ST_SKIP : ST_CMD; // [RULE12]
      cnt_next = '0;
      out_cnt_next = '0;
    end else begin
      unique case (state_reg)
        ST_IDLE, ST_SKIP, ST_EXTRA: ;
        ST_CMD: begin
          if (sck_rise) begin
            op_next = op_full;
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == bslk_pkg::OP_LAST) begin
              cnt_next = '0;
              addr32_next = ADDR4_MODE; // [RULE4]
              if (op_full == bslk_pkg::OP_UNLOCK ||
                  op_full == bslk_pkg::OP_RD_LOCK) begin
                state_next = ST_ADDR;
              end else begin
                state_next = ST_OPDONE;
              end
            end
          end
        end
        ST_ADDR: begin
          if (sck_rise) begin
            addr_next = {addr_reg[30:0], di_sync};
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == addr_last) begin // [RULE4]
              if (!addr32_reg) begin
                addr_next = {8'h00, addr_reg[22:0], di_sync};
              end
              state_next = (op_reg == bslk_pkg::OP_RD_LOCK) ?
                           ST_DATA : ST_OPDONE; // [RULE5]
            end
          end
        end
        ST_OPDONE: begin
          // Surplus clocks spoil the command
          if (sck_rise) begin
            state_next = ST_EXTRA;
          end
        end
        ST_DATA: begin
          if (sck_fall) begin
            // Lock byte repeats; only its LSB carries the lock bit
            sdo_next = (out_cnt_reg == bslk_pkg::OUT_LSB_POS) ?
                       mem_rd_bit : 1'b0; // [RULE6]
            out_cnt_next = out_cnt_reg + 1'b1; // [RULE5]
          end
        end
      endcase
    end
    if (soft_rst_next) begin
      rst_en_next = 1'b0;
    end
    puw_cnt_next = (puw_cnt_reg == PUW_DONE) ? puw_cnt_reg :
                   puw_cnt_reg + 1'b1;
  end
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      op_reg <= '0;
      addr_reg <= '0;
      addr32_reg <= 1'b0;
      out_cnt_reg <= '0;
      sdo_reg <= 1'b0;
      rst_en_reg <= 1'b0;
      rec_cnt_reg <= '0;
      puw_cnt_reg <= '0;
      SOFT_RESET <= 1'b0;
      RESET_BUSY <= 1'b0;
      SDO_OE <= 1'b0;
      LOCK_PROTECT <= 1'b0;
      BP_PROTECT_SEL <= 1'b0;
      BP_PROTECT_CODE <= '0;
      WRITE_READY <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      addr32_reg <= addr32_next;
      out_cnt_reg <= out_cnt_next;
      sdo_reg <= sdo_next;
      rst_en_reg <= rst_en_next;
      rec_cnt_reg <= rec_cnt_next;
      puw_cnt_reg <= puw_cnt_next;
      // Other blocks clear write latch, suspend, P, M and W bits on this
      SOFT_RESET <= soft_rst_next; // [RULE11]
      RESET_BUSY <= rec_cnt_next != '0; // [RULE12]
      SDO_OE <= state_next == ST_DATA; // [RULE5]
      LOCK_PROTECT <= PER_BLOCK_PROTECT_SELECT & mem_rd_bit; // [RULE1]
      BP_PROTECT_SEL <= ~PER_BLOCK_PROTECT_SELECT; // [RULE1]
      BP_PROTECT_CODE <= PER_BLOCK_PROTECT_SELECT ? '0 :
        {COMPLEMENT_PROTECT, TOP_BOTTOM_SELECT, BLOCK_PROTECT_BITS};
      WRITE_READY <= puw_cnt_next == PUW_DONE; // [RULE14]
    end
  end
  assign SDO = sdo_reg;
  logic [bslk_pkg::LOCK_IDX_W-1:0] blk_idx;
  assign blk_idx = lock_index(addr_reg); // [RULE15]
  bslk_lock_mem u_lock_mem (
    .clk(REF_CLK),
    .rst(RST),
    .set_all(lock_set_all),
    .clr_all(lock_clr_all),
    .clr_one(lock_clr_one),
    .wr_idx(blk_idx),
    .rd_idx(blk_idx),
    .rd_bit(mem_rd_bit)
  );
  a_lock_select: assert property ( // [RULE1]
    LOCK_PROTECT |-> $past(PER_BLOCK_PROTECT_SELECT) && $past(mem_rd_bit))
    else $error("lock protect without select");
  a_reset_locked: assert property ( // [RULE2]
    $past(RST) |-> mem_rd_bit)
    else $error("lock bit not set after reset");
  a_unlock_cause: assert property ( // [RULE3]
    lock_clr_one |-> cs_rise && state_reg == ST_OPDONE && op_reg == 8'h39)
    else $error("unlock without full command");
  a_addr_length: assert property ( // [RULE4]
    state_reg == ST_ADDR && state_next != ST_ADDR && !cs_rise && !cs_fall
      |-> cnt_reg == (addr32_reg ? 6'h1F : 6'h17))
    else $error("address length wrong");
  a_read_drive: assert property ( // [RULE5]
    state_reg == ST_DATA && !cs_rise && !cs_fall |=> SDO_OE)
    else $error("readback not driving");
  a_lsb_only: assert property ( // [RULE6]
    $rose(SDO) |-> out_cnt_reg == 3'h0)
    else $error("lock value outside LSB");
  a_global_lock: assert property ( // [RULE7]
    lock_set_all |-> ##2 mem_rd_bit)
    else $error("global lock failed");
  a_global_unlock: assert property ( // [RULE8]
    lock_clr_all |-> ##2 !mem_rd_bit)
    else $error("global unlock failed");
  a_reset_pair: assert property ( // [RULE9]
    $rose(SOFT_RESET) |-> $past(rst_en_reg) && $past(op_reg) == 8'h99)
    else $error("reset without enable");
  a_enable_cancel: assert property ( // [RULE10]
    cs_rise && op_valid && op_reg != 8'h66 |=> !rst_en_reg)
    else $error("reset enable not cancelled");
  a_recover_hold: assert property ( // [RULE12]
    SOFT_RESET |-> RESET_BUSY [*8] ##1 !lock_clr_one)
    else $error("recovery window too short");
  a_write_gate: assert property ( // [RULE14]
    WRITE_READY |-> puw_cnt_reg == PUW_DONE)
    else $error("write ready too early");
endmodule

// *** test/bslk_host.sv ***
// Purpose: Host serial controller model that sends lock and reset frames
// Assumes: Mode 0 framing, serial clock idle low between frames
// Notes: Serial clock period is 16 system clocks, moved on falling edges
`timescale 1ns/100ps
module bslk_host (
  input wire logic clk,
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic cs_n,
  output logic sclk,
  output logic sdi
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b1;
  end

  // Sends nb bits MSB first and keeps the last byte the device drove
  task automatic xfer(input logic [63:0] tx, input int nb,
                      output logic [7:0] rx);
    int i;
    rx = 8'h00;
    @(negedge clk);
    cs_n = 1'b0;
    for (i = nb - 1; i >= 0; i--) begin
      sdi = tx[i];
      repeat (8) @(negedge clk);
      sclk = 1'b1;
      if (sdo_oe === 1'b1) begin
        rx = {rx[6:0], sdo};
      end
      repeat (8) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (8) @(negedge clk);
    cs_n = 1'b1;
    // Toggled so a stale bit is never taken for fresh data
    sdi = ~sdi;
    repeat (16) @(negedge clk);
  endtask
endmodule

// *** test/block_lock_and_soft_reset_tb.sv ***
// Purpose: Self-checking bench for the block lock and soft reset block
// Assumes: Host model drives the serial pins, config pins driven here
// Notes: Power-up write delay shortened to 200 cycles for run time
`timescale 1ns/100ps
module block_lock_and_soft_reset_tb;
  localparam int PUW = 200;
  logic clk, rst, cs_n, sclk, sdi, a4, sel, cmp, tbs;
  logic sdo, sdo_oe, lock_prot, bp_sel, soft_rst, rst_busy, wr_rdy;
  logic [3:0] bp;
  logic [5:0] bp_code;
  logic [7:0] rx;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  int pulses = 0;
  int busy_cyc = 0;
  int n;

  bslk_ctrl #(.PUW_CYCLES(PUW)) bslk_ctrl_i (.REF_CLK(clk), .RST(rst),
    .CS_N(cs_n), .SCLK(sclk), .SERIAL_DATA_IN(sdi), .ADDR4_MODE(a4),
    .PER_BLOCK_PROTECT_SELECT(sel), .COMPLEMENT_PROTECT(cmp),
    .TOP_BOTTOM_SELECT(tbs), .BLOCK_PROTECT_BITS(bp), .SDO(sdo),
    .SDO_OE(sdo_oe), .LOCK_PROTECT(lock_prot), .BP_PROTECT_SEL(bp_sel),
    .BP_PROTECT_CODE(bp_code), .SOFT_RESET(soft_rst),
    .RESET_BUSY(rst_busy), .WRITE_READY(wr_rdy));
  bslk_host bslk_host_i (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe),
    .cs_n(cs_n), .sclk(sclk), .sdi(sdi));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cycle budget is about four times the expected run
  always @(posedge clk) begin
    cycles++;
    if (soft_rst === 1'b1) pulses++;
    if (rst_busy === 1'b1) busy_cyc++;
    if (cycles == 40000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      miscompares++;
    end
  endtask

  task automatic cmd(input logic [7:0] op);
    bslk_host_i.xfer({56'h0, op}, 8, rx);
  endtask

  task automatic unlock(input logic [31:0] ad);
    if (a4) begin
      bslk_host_i.xfer({24'h0, bslk_pkg::OP_UNLOCK, ad}, 40, rx);
    end else begin
      bslk_host_i.xfer({32'h0, bslk_pkg::OP_UNLOCK, ad[23:0]}, 32, rx);
    end
  endtask

  // Address, then eight read clocks for the lock byte
  task automatic rd(input logic [31:0] ad, input logic [7:0] exp);
    if (a4) begin
      bslk_host_i.xfer({16'h0, bslk_pkg::OP_RD_LOCK, ad, 8'h00}, 48, rx);
    end else begin
      bslk_host_i.xfer({24'h0, bslk_pkg::OP_RD_LOCK, ad[23:0], 8'h00},
                       40, rx);
    end
    chk("lock byte", {24'h0, exp}, {24'h0, rx});
  endtask

  task automatic stop_test;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    a4 = 1'b0;
    sel = 1'b1;
    cmp = 1'b0;
    tbs = 1'b0;
    bp = 4'h0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("write ready", 32'h0, {31'h0, wr_rdy});
    repeat (4) @(negedge clk);
    rd(32'h0005_0000, 8'h01);
    unlock(32'h0005_0000);
    rd(32'h0005_0000, 8'h00);
    rd(32'h0006_0000, 8'h01);
    a4 = 1'b1;
    unlock(32'h0107_0000);
    rd(32'h0107_0000, 8'h00);
    a4 = 1'b0;
    chk("write ready", 32'h1, {31'h0, wr_rdy});
    cmd(bslk_pkg::OP_GLB_LOCK);
    rd(32'h0005_0000, 8'h01);
    repeat (2) @(negedge clk);
    chk("lock protect", 32'h1, {31'h0, lock_prot});
    chk("bp select", 32'h0, {31'h0, bp_sel});
    chk("bp code", 32'h0, {26'h0, bp_code});
    sel = 1'b0;
    cmp = 1'b1;
    bp = 4'hA;
    repeat (2) @(negedge clk);
    chk("lock protect", 32'h0, {31'h0, lock_prot});
    chk("bp select", 32'h1, {31'h0, bp_sel});
    chk("bp code", 32'h2A, {26'h0, bp_code});
    sel = 1'b1;
    cmd(bslk_pkg::OP_GLB_UNLOCK);
    rd(32'h00FF_0000, 8'h00);
    cmd(bslk_pkg::OP_RST_EN);
    cmd(bslk_pkg::OP_GLB_UNLOCK);
    cmd(bslk_pkg::OP_RST);
    chk("reset pulses", 32'h0, pulses);
    rd(32'h00FF_0000, 8'h00);
    // Host has checked busy is low before the reset pair
    chk("busy before", 32'h0, {31'h0, rst_busy});
    cmd(bslk_pkg::OP_RST_EN);
    cmd(bslk_pkg::OP_RST);
    chk("reset pulses", 32'h1, pulses);
    chk("reset busy", 32'h1, {31'h0, rst_busy});
    cmd(bslk_pkg::OP_GLB_UNLOCK);
    for (n = 0; n < 4000 && rst_busy !== 1'b0; n++) begin
      @(negedge clk);
    end
    chk("busy cycles", bslk_pkg::RST_CYC, busy_cyc);
    rd(32'h00FF_0000, 8'h01);
    stop_test();
  end
endmodule
